// ---- logic/reset_cause_capture.sv ----
`timescale 1ns/10ps
// Function
// - Read-only flags show last reset cause
// - Debug forced reset sets no flags
// - Any status write restarts watchdog, flags unchanged
// - Power-on sets power-on and low-voltage flags
// - Low-voltage reset keeps power-on, sets low-voltage
// - Other resets capture active sources, clear two
// - Reset pin low sets pin flag
// - Watchdog timeout sets flag, blocked when disabled
// - Illegal opcode, disabled stop, disabled background trigger reset
// - RAM to high-page gap access resets
// - High-page to flash gap access resets
// - Reserved register locations are not illegal
// - Clock generator request sets its flag
// - Both enables and trip cause low-voltage reset
// - Force register reads zero, one bit
// - User program writes to force ignored
// - Debug write of bit 0 forces reset
// - Watchdog enable write-once, defaults to one
module reset_cause_capture #(
  parameter int unsigned WDOG_TIMEOUT = reset_cause_pkg::WDOG_TIMEOUT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire reset_cause_pkg::bus_req_type bus_i,
  input wire logic reset_pin_n_i,
  input wire logic low_voltage_i,
  input wire logic low_volt_reset_enable_i,
  input wire logic low_volt_stop_enable_i,
  input wire logic stop_enable_i,
  input wire logic background_mode_enable_i,
  input wire logic opcode_unimpl_i,
  input wire logic stop_exec_i,
  input wire logic enter_background_instr_i,
  input wire logic clock_gen_fault_i,
  input wire logic wdog_cfg_wr_i,
  input wire logic wdog_cfg_enable_i,
  output logic [7:0] rd_data_o,
  output logic sys_reset_o,
  output logic watchdog_enable_o
);
  localparam int unsigned HOLD_W =
    $clog2(reset_cause_pkg::RESET_HOLD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST =
    HOLD_W'(reset_cause_pkg::RESET_HOLD_CYCLES - 1);

  // Address inside one of the two illegal gaps
  function automatic logic in_gap(input logic [15:0] addr);
    in_gap = (addr >= reset_cause_pkg::RAM_GAP_LO &&
              addr <= reset_cause_pkg::RAM_GAP_HI) ||
             (addr >= reset_cause_pkg::FLASH_GAP_LO &&
              addr <= reset_cause_pkg::FLASH_GAP_HI);
  endfunction

  // Write strobe to a given register address
  function automatic logic wr_to(input reset_cause_pkg::bus_req_type req,
                                 input logic [15:0] addr);
    wr_to = req.wr && (req.addr == addr);
  endfunction

  logic [2:0] sync_q [2];
  logic [1:0] pin_level;
  logic [1:0] async_in;
  reset_cause_pkg::seq_state_type state;
  reset_cause_pkg::seq_state_type next_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic [HOLD_W-1:0] next_hold_cnt;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic sys_reset;
  logic next_sys_reset;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic wdog_en;
  logic next_wdog_en;
  logic wdog_locked;
  logic next_wdog_locked;
  logic wdog_expired;
  logic wdog_kick;
  logic lv_trip;
  logic pin_low;
  logic any_src;
  logic cpu_access;
  reset_cause_pkg::reset_src_type src;

  assign async_in = {low_voltage_i, reset_pin_n_i};

  // Three-stage synchronisers; level moves once stages two and three agree
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      logic [2:0] next_sync;
      logic next_level;
      always_comb
      begin
        next_sync = {sync_q[i][1:0], async_in[i]};
        next_level = pin_level[i];
        if (sync_q[i][1] == sync_q[i][2])
          next_level = sync_q[i][2];
      end
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          sync_q[i] <= {3{reset_cause_pkg::SYNC_RESET_LEVEL[i]}};
          pin_level[i] <= reset_cause_pkg::SYNC_RESET_LEVEL[i];
        end
        else if (ce_i)
        begin
          sync_q[i] <= next_sync;
          pin_level[i] <= next_level;
        end
      end
    end
  endgenerate

  // Reset sources seen while running
  assign pin_low = !pin_level[0];
  assign lv_trip = pin_level[1] && low_volt_reset_enable_i &&
                   low_volt_stop_enable_i;
  assign cpu_access = (bus_i.rd || bus_i.wr) && !bus_i.bdm;
  assign src.pin = pin_low;
  assign src.watchdog = wdog_expired && wdog_en;
  assign src.illegal_opcode = opcode_unimpl_i ||
    (stop_exec_i && !stop_enable_i) ||
    (enter_background_instr_i && !background_mode_enable_i);
  // Only the two gaps are illegal; register areas never are
  assign src.illegal_addr =
    cpu_access && in_gap(bus_i.addr);
  assign src.clock_gen = clock_gen_fault_i;
  // Only a debug-origin write of bit 0 forces reset
  assign src.force_req = wr_to(bus_i, reset_cause_pkg::FORCE_RESET_ADDR) &&
    bus_i.bdm &&
    bus_i.wdata[reset_cause_pkg::FORCE_RESET_BIT];
  assign any_src = lv_trip || (|src);

  // Any write to the status address restarts the watchdog
  assign wdog_kick = (state == reset_cause_pkg::SEQ_RUN) &&
    wr_to(bus_i, reset_cause_pkg::RESET_CAUSE_ADDR);

  watchdog_timer #(
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_watchdog (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .enable_i(wdog_en),
    .kick_i(wdog_kick),
    .clear_i(sys_reset),
    .expired_o(wdog_expired)
  );

  // Reset sequencer and cause capture
  always_comb
  begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_flags = flags;
    case (state)
      reset_cause_pkg::SEQ_RUN:
      begin
        if (any_src)
        begin
          next_state = reset_cause_pkg::SEQ_HOLD;
          next_hold_cnt = '0;
          next_flags = '0;
          if (lv_trip)
          begin
            next_flags[reset_cause_pkg::POWER_ON_BIT] =
              flags[reset_cause_pkg::POWER_ON_BIT];
            next_flags[reset_cause_pkg::LOW_VOLTAGE_BIT] = 1'b1;
          end
          else
          begin
            // Power-on and low-voltage stay clear; force adds nothing
            next_flags[reset_cause_pkg::PIN_BIT] = src.pin;
            next_flags[reset_cause_pkg::WATCHDOG_BIT] =
              src.watchdog;
            next_flags[reset_cause_pkg::ILLEGAL_OPCODE_BIT] =
              src.illegal_opcode;
            next_flags[reset_cause_pkg::ILLEGAL_ADDR_BIT] =
              src.illegal_addr;
            next_flags[reset_cause_pkg::CLOCK_GEN_BIT] =
              src.clock_gen;
          end
        end
      end
      reset_cause_pkg::SEQ_HOLD:
      begin
        // Hold the reset while the pin or the supply is still bad
        if (hold_cnt != HOLD_LAST)
          next_hold_cnt = hold_cnt + HOLD_W'(1);
        else if (!pin_low && !lv_trip)
          next_state = reset_cause_pkg::SEQ_RUN;
      end
      default:
        next_state = reset_cause_pkg::SEQ_HOLD;
    endcase
    next_sys_reset = (next_state == reset_cause_pkg::SEQ_HOLD);
  end

  // Write-once watchdog enable, rearmed by every reset
  always_comb
  begin
    next_wdog_en = wdog_en;
    next_wdog_locked = wdog_locked;
    if (sys_reset)
    begin
      next_wdog_en = reset_cause_pkg::WATCHDOG_ENABLE_RESET;
      next_wdog_locked = 1'b0;
    end
    else if (wdog_cfg_wr_i && !wdog_locked)
    begin
      next_wdog_en = wdog_cfg_enable_i;
      next_wdog_locked = 1'b1;
    end
  end

  // Read data, loaded on each read; only CPU reads in the two gaps change anything else
  always_comb
  begin
    next_rd_data = rd_data;
    if (bus_i.rd)
    begin
      if (bus_i.addr == reset_cause_pkg::RESET_CAUSE_ADDR)
        next_rd_data = {flags[7:1], 1'b0};
      else if (bus_i.addr == reset_cause_pkg::FORCE_RESET_ADDR)
        next_rd_data = reset_cause_pkg::FORCE_READ_VALUE;
      else
        next_rd_data = '0;
    end
  end

  // Power-on reset loads the power-on cause pattern
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= reset_cause_pkg::SEQ_RUN;
      hold_cnt <= '0;
      flags <= reset_cause_pkg::CAUSE_POR_VALUE;
      sys_reset <= 1'b0;
      rd_data <= '0;
      wdog_en <= reset_cause_pkg::WATCHDOG_ENABLE_RESET;
      wdog_locked <= 1'b0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      flags <= next_flags;
      sys_reset <= next_sys_reset;
      rd_data <= next_rd_data;
      wdog_en <= next_wdog_en;
      wdog_locked <= next_wdog_locked;
    end
  end

  assign rd_data_o = rd_data;
  assign sys_reset_o = sys_reset;
  assign watchdog_enable_o = wdog_en;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_enter;
    ce_i && state == reset_cause_pkg::SEQ_RUN && any_src;
  endsequence

  sequence seq_enter_other;
    seq_enter and !lv_trip;
  endsequence

  chk_force_none: assert property (
    seq_enter_other and src == 6'h01 |=> flags == 8'h00)
    else $error("forced reset left a cause flag set");

  chk_kick_stable: assert property (
    wdog_kick && ce_i && !any_src |=> $stable(flags) && state == $past(state))
    else $error("status write disturbed the cause flags");

  chk_lv_keep_por: assert property (
    seq_enter and lv_trip |=> flags[7] == $past(flags[7]) &&
    flags[6:0] == 7'h02 && sys_reset_o)
    else $error("low-voltage reset captured wrong flags");

  chk_other_clear: assert property (
    seq_enter_other |=> !flags[7] && !flags[1] ##1 sys_reset_o)
    else $error("other reset left power-on or low-voltage set");

  chk_pin_flag: assert property (
    seq_enter_other and pin_low |=> flags[6])
    else $error("pin reset flag missing");

  chk_wdog_blocked: assert property (
    ce_i && !wdog_en |=> !wdog_expired)
    else $error("watchdog reset while disabled");

  chk_illegal_addr: assert property (
    seq_enter_other and src.illegal_addr |=> flags[3] && sys_reset_o)
    else $error("illegal address did not reset");

  chk_user_force: assert property (
    ce_i && state == reset_cause_pkg::SEQ_RUN && !lv_trip &&
    src[5:1] == 5'h00 && !bus_i.bdm &&
    wr_to(bus_i, reset_cause_pkg::FORCE_RESET_ADDR) |=> !sys_reset_o)
    else $error("user write forced a reset");

  chk_force_read: assert property (
    ce_i && bus_i.rd && bus_i.addr == reset_cause_pkg::FORCE_RESET_ADDR
    |=> rd_data_o == 8'h00)
    else $error("force register read not zero");

  chk_status_read: assert property (
    ce_i && bus_i.rd && bus_i.addr == reset_cause_pkg::RESET_CAUSE_ADDR &&
    !(state == reset_cause_pkg::SEQ_RUN && any_src)
    |=> rd_data_o == {$past(flags[7:1]), 1'b0} && $stable(flags))
    else $error("status read wrong or had a side effect");

  chk_wdog_once: assert property (
    ce_i && wdog_locked && !sys_reset |=> $stable(wdog_en))
    else $error("watchdog enable changed after first write");

  chk_wdog_rearm: assert property (
    ce_i && sys_reset |=> wdog_en && !wdog_locked)
    else $error("watchdog enable not rearmed by reset");

endmodule

// ---- include/reset_cause_pkg.sv ----
package reset_cause_pkg;

  // Clock and sequencing times
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_HOLD_NS = 640;
  localparam int unsigned RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_TIMEOUT_CYCLES = 262144;

  // Register addresses on the CPU bus
  localparam logic [15:0] RESET_CAUSE_ADDR = 16'h1800;
  localparam logic [15:0] FORCE_RESET_ADDR = 16'h1801;

  // Illegal address gaps
  localparam logic [15:0] RAM_GAP_LO = 16'h0470;
  localparam logic [15:0] RAM_GAP_HI = 16'h17ff;
  localparam logic [15:0] FLASH_GAP_LO = 16'h1860;
  localparam logic [15:0] FLASH_GAP_HI = 16'hbfff;

  // Reset cause field positions
  localparam int unsigned POWER_ON_BIT = 7;
  localparam int unsigned PIN_BIT = 6;
  localparam int unsigned WATCHDOG_BIT = 5;
  localparam int unsigned ILLEGAL_OPCODE_BIT = 4;
  localparam int unsigned ILLEGAL_ADDR_BIT = 3;
  localparam int unsigned CLOCK_GEN_BIT = 2;
  localparam int unsigned LOW_VOLTAGE_BIT = 1;
  localparam int unsigned FORCE_RESET_BIT = 0;

  // Reset values
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h82;
  localparam logic [7:0] FORCE_READ_VALUE = 8'h00;
  localparam logic WATCHDOG_ENABLE_RESET = 1'h1;
  localparam logic [1:0] SYNC_RESET_LEVEL = 2'h1;

  // One CPU or debug bus access
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic bdm;
    logic [7:0] wdata;
  } bus_req_type;

  // Reset requests other than low voltage
  typedef struct packed {
    logic pin;
    logic watchdog;
    logic illegal_opcode;
    logic illegal_addr;
    logic clock_gen;
    logic force_req;
  } reset_src_type;

  typedef enum logic [0:0] {
    SEQ_RUN = 1'b0,
    SEQ_HOLD = 1'b1
  } seq_state_type;

endpackage

// ---- logic/watchdog_timer.sv ----
`timescale 1ns/10ps
module watchdog_timer #(
  parameter int unsigned TIMEOUT = reset_cause_pkg::WDOG_TIMEOUT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic kick_i,
  input wire logic clear_i,
  output logic expired_o
);
  localparam int unsigned CNT_W = $clog2(TIMEOUT + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic expired;
  logic next_expired;

  // Count while enabled, restart on kick or system reset
  always_comb
  begin
    next_count = count;
    next_expired = 1'b0;
    if (clear_i || kick_i || !enable_i)
      next_count = '0;
    else if (count == LAST)
    begin
      next_count = '0;
      next_expired = 1'b1;
    end
    else
      next_count = count + CNT_W'(1);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count <= '0;
      expired <= 1'b0;
    end
    else if (ce_i)
    begin
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign expired_o = expired;

  // A kick restarts the count
  chk_kick_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && kick_i |=> count == '0 && !expired)
    else $error("watchdog count not restarted by kick");

endmodule

// ---- dv/debug_host_model.sv ----
`timescale 1ns/10ps
module debug_host_model (
  input wire logic clk_i,
  output reset_cause_pkg::bus_req_type bus_o
);
  // Idle until the host sends a command
  initial
  begin
    bus_o = '0;
  end

  // Background byte write: one debug-origin bus cycle, then release
  task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    bus_o = '{addr: addr, rd: 1'b0, wr: 1'b1, bdm: 1'b1, wdata: data};
    @(negedge clk_i);
    // Released address and data lines show the inverse of the last value; strobes drop low
    bus_o = '{addr: ~addr, rd: 1'b0, wr: 1'b0, bdm: 1'b0, wdata: ~data};
  endtask
endmodule

// ---- dv/reset_cause_capture_tb.sv ----
`timescale 1ns/10ps
module reset_cause_capture_tb;
  localparam int unsigned WDOG = 150;
  logic clk_i, rstn_i, ce_i, reset_pin_n_i, low_voltage_i;
  logic lv_re, lv_se, stop_enable_i, background_mode_enable_i;
  logic opcode_unimpl_i, stop_exec_i, enter_background_instr_i;
  logic clock_gen_fault_i, wdog_cfg_wr_i, wdog_cfg_enable_i;
  logic [7:0] rd_data_o;
  logic sys_reset_o, watchdog_enable_o;
  reset_cause_pkg::bus_req_type cpu_bus, host_bus, bus_i;
  int fail_count, check_count;

  // Debug host owns the bus only while it writes
  assign bus_i = host_bus.wr ? host_bus : cpu_bus;

  debug_host_model host (.clk_i(clk_i), .bus_o(host_bus));

  reset_cause_capture #(.WDOG_TIMEOUT(WDOG)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_i(bus_i),
    .reset_pin_n_i(reset_pin_n_i), .low_voltage_i(low_voltage_i),
    .low_volt_reset_enable_i(lv_re), .low_volt_stop_enable_i(lv_se),
    .stop_enable_i(stop_enable_i),
    .background_mode_enable_i(background_mode_enable_i),
    .opcode_unimpl_i(opcode_unimpl_i), .stop_exec_i(stop_exec_i),
    .enter_background_instr_i(enter_background_instr_i),
    .clock_gen_fault_i(clock_gen_fault_i), .wdog_cfg_wr_i(wdog_cfg_wr_i),
    .wdog_cfg_enable_i(wdog_cfg_enable_i), .rd_data_o(rd_data_o),
    .sys_reset_o(sys_reset_o), .watchdog_enable_o(watchdog_enable_o)
  );

  // Bus clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // One CPU bus access, strobe held for one clock
  task automatic bus(input logic rd, input logic wr, input logic bdm,
                     input logic [15:0] a, input logic [7:0] wd,
                     output logic [7:0] rdata);
    @(negedge clk_i);
    cpu_bus = '{addr: a, rd: rd, wr: wr, bdm: bdm, wdata: wd};
    @(negedge clk_i);
    cpu_bus = '{addr: ~a, rd: 1'b0, wr: 1'b0, bdm: 1'b0, wdata: ~wd};
    rdata = rd_data_o;
  endtask

  task automatic read_reg(input string name, input logic [15:0] a,
                          input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b1, 1'b0, 1'b0, a, 8'h00, d);
    check(name, exp, d);
  endtask

  task automatic kick;
    logic [7:0] d;
    bus(1'b0, 1'b1, 1'b0, reset_cause_pkg::RESET_CAUSE_ADDR, 8'hff, d);
  endtask

  task automatic expect_none(input string name, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      check(name, 8'h00, {7'h00, sys_reset_o});
    end
  endtask

  task automatic wait_reset(input string name, input int n);
    int i;
    i = 0;
    while (sys_reset_o !== 1'b1 && i < n)
    begin
      @(negedge clk_i);
      i++;
    end
    check(name, 8'h01, {7'h00, sys_reset_o});
  endtask

  // Wait out the hold, restart the watchdog, then read the flags
  task automatic finish_reset(input string name, input logic [7:0] exp,
                              output int n);
    n = 0;
    while (sys_reset_o === 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    kick();
    read_reg(name, reset_cause_pkg::RESET_CAUSE_ADDR, exp);
  endtask

  task automatic cfg(input logic v);
    @(negedge clk_i);
    wdog_cfg_wr_i = 1'b1;
    wdog_cfg_enable_i = v;
    @(negedge clk_i);
    wdog_cfg_wr_i = 1'b0;
  endtask

  task automatic t_power_on;
    read_reg("flags at power-on", 16'h1800, 8'h82);
    read_reg("force reg read", 16'h1801, 8'h00);
    read_reg("unused address read", 16'h1802, 8'h00);
    check("watchdog enable", 8'h01, {7'h00, watchdog_enable_o});
  endtask

  task automatic t_status_write;
    logic [7:0] d;
    bus(1'b0, 1'b1, 1'b1, 16'h1800, 8'h7d, d);
    expect_none("status write", 4);
    read_reg("flags after write", 16'h1800, 8'h82);
  endtask

  task automatic t_lv(input logic [7:0] exp);
    int n;
    lv_re = 1'b1;
    lv_se = 1'b0;
    low_voltage_i = 1'b1;
    expect_none("one low-voltage enable", 8);
    lv_se = 1'b1;
    wait_reset("low-voltage reset", 8);
    repeat (3) @(negedge clk_i);
    low_voltage_i = 1'b0;
    finish_reset("low-voltage flags", exp, n);
  endtask

  task automatic t_forces;
    logic [7:0] d;
    int n;
    bus(1'b0, 1'b1, 1'b0, 16'h1801, 8'h01, d);
    expect_none("cpu force write", 8);
    read_reg("force reg after write", 16'h1801, 8'h00);
    host.write_byte(16'h1801, 8'hfe);
    expect_none("force bit clear", 8);
    host.write_byte(16'h1801, 8'h01);
    wait_reset("debug force", 0);
    finish_reset("flags after force", 8'h00, n);
    check("force hold", 8'(reset_cause_pkg::RESET_HOLD_CYCLES),
          8'(n));
  endtask

  task automatic t_pin;
    int n;
    reset_pin_n_i = 1'b0;
    wait_reset("pin reset", 6);
    repeat (4) @(negedge clk_i);
    reset_pin_n_i = 1'b1;
    finish_reset("pin flags", 8'h40, n);
  endtask

  // Pulse sources, illegal and legal addresses
  task automatic t_sources;
    logic [7:0] d;
    logic [7:0] exp;
    int n;
    logic [15:0] addrs [8] = '{16'h0470, 16'h17ff, 16'h1860, 16'hbfff,
                               16'h046f, 16'hc000, 16'h1802, 16'h0470};
    for (int k = 0; k < 14; k++)
    begin
      stop_enable_i = (k == 2);
      background_mode_enable_i = (k == 4);
      exp = (k < 5) ? 8'h10 : ((k == 5) ? 8'h04 : 8'h08);
      opcode_unimpl_i = (k == 0);
      stop_exec_i = (k == 1 || k == 2);
      enter_background_instr_i = (k == 3 || k == 4);
      clock_gen_fault_i = (k == 5);
      if (k < 6)
      begin
        @(negedge clk_i);
        {opcode_unimpl_i, stop_exec_i} = 2'h0;
        {enter_background_instr_i, clock_gen_fault_i} = 2'h0;
      end
      else
        bus(1'b1, 1'b0, (k == 13), addrs[k-6], 8'h00, d);
      if (k == 2 || k == 4 || k > 9)
        expect_none($sformatf("no reset %0d", k), 10);
      else
      begin
        wait_reset($sformatf("reset %0d", k), 0);
        finish_reset($sformatf("flags %0d", k), exp, n);
      end
    end
  endtask

  task automatic t_watchdog;
    int n;
    kick();
    for (int i = 0; i < 3; i++)
    begin
      expect_none("kicked watchdog", 100);
      kick();
    end
    wait_reset("watchdog expiry", 200);
    finish_reset("watchdog flags", 8'h20, n);
    check("enable rearmed", 8'h01, {7'h00, watchdog_enable_o});
    cfg(1'b0);
    cfg(1'b1);
    check("enable write-once", 8'h00, {7'h00, watchdog_enable_o});
    expect_none("watchdog disabled", 250);
  endtask

  // Clock enable low freezes the block, so a pulse is not taken
  task automatic t_freeze;
    @(negedge clk_i);
    ce_i = 1'b0;
    opcode_unimpl_i = 1'b1;
    @(negedge clk_i);
    opcode_unimpl_i = 1'b0;
    expect_none("frozen by clock enable", 4);
    ce_i = 1'b1;
    expect_none("after clock enable", 4);
  endtask

  // Power-on again in mid-run reloads the power-on pattern
  task automatic t_por_again;
    @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    check("enable after power-on", 8'h01,
          {7'h00, watchdog_enable_o});
    read_reg("flags after power-on", 16'h1800, 8'h82);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Run takes about 1800 cycles; give it nearly three times that
  initial
  begin
    #50000;
    fail_count++;
    results();
  end

  initial
  begin
    fail_count = 0;
    check_count = 0;
    cpu_bus = '0;
    ce_i = 1'b1;
    rstn_i = 1'b0;
    reset_pin_n_i = 1'b1;
    {low_voltage_i, lv_re, lv_se, stop_enable_i} = 4'h0;
    {background_mode_enable_i, opcode_unimpl_i, stop_exec_i} = 3'h0;
    {enter_background_instr_i, clock_gen_fault_i} = 2'h0;
    {wdog_cfg_wr_i, wdog_cfg_enable_i} = 2'h0;
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    t_power_on();
    t_status_write();
    t_lv(8'h82);
    t_forces();
    t_pin();
    t_sources();
    t_freeze();
    t_lv(8'h02);
    t_watchdog();
    t_por_again();
    results();
  end
endmodule
